/* File: pkg/rlc_pkg.sv */
// Package for the receive lane 4..6 control register bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`default_nettype none
package rlc_pkg;
  localparam int          RLC_AW         = 8;
  localparam int          RLC_DW         = 32;
  localparam int          RLC_NLANE      = 3;
  localparam int          RLC_PD_W       = 8;
  localparam logic [7:0]  RLC_LANE4_OFF  = 8'h14;
  localparam logic [7:0]  RLC_LANE5_OFF  = 8'h18;
  localparam logic [7:0]  RLC_LANE6_OFF  = 8'h1C;
  localparam int          RLC_INV_BIT    = 0;
  localparam int          RLC_PD_BIT     = 1;
  localparam int          RLC_SPARE_BIT  = 2;
  localparam int          RLC_FIELD_W    = 3;
  localparam logic [2:0]  RLC_CTRL_RST   = 3'h4;
  localparam int          RLC_LANE4_IDX  = 4;
  localparam int          RLC_LANE5_IDX  = 2;
  localparam int          RLC_LANE6_IDX  = 6;
  localparam logic [31:0] RLC_UNMAPPED   = 32'h0000_0000;
endpackage : rlc_pkg
`default_nettype wire

/* File: hw/rlc_regs.sv */
// Control registers for receive lanes 4, 5 and 6 with data inversion.
// Assumes classic Wishbone master on ref_clk; lane data on the same clock.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module rlc_regs #(
  parameter int LANE_W = 32
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [rlc_pkg::RLC_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [rlc_pkg::RLC_DW-1:0]   wb_dat_i,
  output logic      [rlc_pkg::RLC_DW-1:0]   wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic [LANE_W-1:0]            lane4_rx_data,
  input  wire logic [LANE_W-1:0]            lane5_rx_data,
  input  wire logic [LANE_W-1:0]            lane6_rx_data,
  output logic      [LANE_W-1:0]            lane4_data_out,
  output logic      [LANE_W-1:0]            lane5_data_out,
  output logic      [LANE_W-1:0]            lane6_data_out,
  output logic      [rlc_pkg::RLC_PD_W-1:0] lane_powerdown
);
  localparam int FW = rlc_pkg::RLC_FIELD_W;

  logic [FW-1:0]               ctrl_r   [rlc_pkg::RLC_NLANE];
  logic [FW-1:0]               ctrl_nxt [rlc_pkg::RLC_NLANE];
  logic [rlc_pkg::RLC_AW-1:0]  lane_off [rlc_pkg::RLC_NLANE];
  logic [LANE_W-1:0]           rx_in    [rlc_pkg::RLC_NLANE];
  logic [LANE_W-1:0]           rx_r     [rlc_pkg::RLC_NLANE];
  logic [LANE_W-1:0]           rx_nxt   [rlc_pkg::RLC_NLANE];
  logic                        ack_r;
  logic                        ack_nxt;
  logic [rlc_pkg::RLC_DW-1:0]  dat_r;
  logic [rlc_pkg::RLC_DW-1:0]  dat_nxt;
  logic                        req;

  assign lane_off[0] = rlc_pkg::RLC_LANE4_OFF;
  assign lane_off[1] = rlc_pkg::RLC_LANE5_OFF;
  assign lane_off[2] = rlc_pkg::RLC_LANE6_OFF;
  assign rx_in[0]    = lane4_rx_data;
  assign rx_in[1]    = lane5_rx_data;
  assign rx_in[2]    = lane6_rx_data;
  assign req         = wb_cyc_i && wb_stb_i && !ack_r;

  // Bus answer and register writes
  always_comb begin
    ack_nxt = req;
    dat_nxt = dat_r;
    for (int i = 0; i < rlc_pkg::RLC_NLANE; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      if (req && wb_adr_i == lane_off[i]) begin
        if (wb_we_i && wb_sel_i[0]) begin
          ctrl_nxt[i] = wb_dat_i[FW-1:0];
        end
      end
    end
    if (req && !wb_we_i) begin
      dat_nxt = rlc_pkg::RLC_UNMAPPED;
      for (int i = 0; i < rlc_pkg::RLC_NLANE; i++) begin
        if (wb_adr_i == lane_off[i]) begin
          dat_nxt = {{(rlc_pkg::RLC_DW-FW){1'b0}}, ctrl_r[i]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      for (int i = 0; i < rlc_pkg::RLC_NLANE; i++) begin
        ctrl_r[i] <= rlc_pkg::RLC_CTRL_RST;
      end
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      for (int i = 0; i < rlc_pkg::RLC_NLANE; i++) begin
        ctrl_r[i] <= ctrl_nxt[i];
      end
    end
  end

  // Per-lane receive data inversion, registered
  genvar g;
  generate
    for (g = 0; g < rlc_pkg::RLC_NLANE; g++) begin : g_lane
      always_comb begin
        rx_nxt[g] = ctrl_r[g][rlc_pkg::RLC_INV_BIT] ? ~rx_in[g] : rx_in[g];
      end
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          rx_r[g] <= '0;
        end else begin
          rx_r[g] <= rx_nxt[g];
        end
      end
    end
  endgenerate

  assign lane4_data_out = rx_r[0];
  assign lane5_data_out = rx_r[1];
  assign lane6_data_out = rx_r[2];
  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = dat_r;

  // Power-down vector; unlisted elements stay low
  always_comb begin
    lane_powerdown = '0;
    lane_powerdown[rlc_pkg::RLC_LANE4_IDX] = ctrl_r[0][rlc_pkg::RLC_PD_BIT];
    lane_powerdown[rlc_pkg::RLC_LANE5_IDX] = ctrl_r[1][rlc_pkg::RLC_PD_BIT];
    lane_powerdown[rlc_pkg::RLC_LANE6_IDX] = ctrl_r[2][rlc_pkg::RLC_PD_BIT];
  end

  // Checks
  sequence s_req;
    wb_cyc_i && wb_stb_i && !ack_r;
  endsequence

  ack_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  inv_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && ctrl_r[0][rlc_pkg::RLC_INV_BIT] |=> lane4_data_out == ~$past(lane4_rx_data))
    else $error("lane 4 data not inverted");
  pass_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !ctrl_r[1][rlc_pkg::RLC_INV_BIT] |=> lane5_data_out == $past(lane5_rx_data))
    else $error("lane 5 data altered without inversion");
  pd4_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lane_powerdown[rlc_pkg::RLC_LANE4_IDX] == ctrl_r[0][rlc_pkg::RLC_PD_BIT])
    else $error("lane 4 power-down not on element 4");
  pd6_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lane_powerdown[rlc_pkg::RLC_LANE6_IDX] == ctrl_r[2][rlc_pkg::RLC_PD_BIT])
    else $error("lane 6 power-down not on element 6");
  pd5_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lane_powerdown[rlc_pkg::RLC_LANE5_IDX] == ctrl_r[1][rlc_pkg::RLC_PD_BIT])
    else $error("lane 5 power-down not on element 2");
  pd_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_req and (wb_we_i && wb_sel_i[0] && wb_adr_i == rlc_pkg::RLC_LANE4_OFF)
    |=> lane_powerdown[rlc_pkg::RLC_LANE4_IDX] == $past(wb_dat_i[rlc_pkg::RLC_PD_BIT]))
    else $error("power-down write not taken");
  spare_rst_a: assert property (@(posedge ref_clk)
    !rst_n |=> ctrl_r[1][rlc_pkg::RLC_SPARE_BIT] && !lane_powerdown[rlc_pkg::RLC_LANE5_IDX])
    else $error("spare bit not one after reset");
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |-> wb_dat_o[rlc_pkg::RLC_DW-1:FW] == '0)
    else $error("reserved bits read non-zero");

  // Requests as the slave takes them
  sequence s_wr4;
    wb_cyc_i && wb_stb_i && !ack_r && wb_we_i && wb_sel_i[0]
      && wb_adr_i == rlc_pkg::RLC_LANE4_OFF;
  endsequence
  sequence s_wr5;
    wb_cyc_i && wb_stb_i && !ack_r && wb_we_i && wb_sel_i[0]
      && wb_adr_i == rlc_pkg::RLC_LANE5_OFF;
  endsequence
  sequence s_wr6;
    wb_cyc_i && wb_stb_i && !ack_r && wb_we_i && wb_sel_i[0]
      && wb_adr_i == rlc_pkg::RLC_LANE6_OFF;
  endsequence
  sequence s_wr_masked;
    wb_cyc_i && wb_stb_i && !ack_r && wb_we_i && !wb_sel_i[0];
  endsequence
  sequence s_rd_unmapped;
    wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i && wb_adr_i != rlc_pkg::RLC_LANE4_OFF
      && wb_adr_i != rlc_pkg::RLC_LANE5_OFF && wb_adr_i != rlc_pkg::RLC_LANE6_OFF;
  endsequence

  pass4_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !ctrl_r[0][rlc_pkg::RLC_INV_BIT] |=> lane4_data_out == $past(lane4_rx_data))
    else $error("lane 4 data altered without inversion");
  inv5_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && ctrl_r[1][rlc_pkg::RLC_INV_BIT] |=> lane5_data_out == ~$past(lane5_rx_data))
    else $error("lane 5 data not inverted");
  inv6_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && ctrl_r[2][rlc_pkg::RLC_INV_BIT] |=> lane6_data_out == ~$past(lane6_rx_data))
    else $error("lane 6 data not inverted");
  pass6_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !ctrl_r[2][rlc_pkg::RLC_INV_BIT] |=> lane6_data_out == $past(lane6_rx_data))
    else $error("lane 6 data altered without inversion");
  inv_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wr5 |=> ctrl_r[1][rlc_pkg::RLC_INV_BIT] == $past(wb_dat_i[rlc_pkg::RLC_INV_BIT]))
    else $error("lane 5 polarity write not taken");
  pd5_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wr5 |=> lane_powerdown[rlc_pkg::RLC_LANE5_IDX] == $past(wb_dat_i[rlc_pkg::RLC_PD_BIT]))
    else $error("lane 5 power-down write not on element 2");
  pd6_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wr6 |=> lane_powerdown[rlc_pkg::RLC_LANE6_IDX] == $past(wb_dat_i[rlc_pkg::RLC_PD_BIT]))
    else $error("lane 6 power-down write not on element 6");
  spare_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wr6 |=> ctrl_r[2][rlc_pkg::RLC_SPARE_BIT] == $past(wb_dat_i[rlc_pkg::RLC_SPARE_BIT]))
    else $error("spare bit write not taken");
  rsvd_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wr4 |=> ctrl_r[0] == $past(wb_dat_i[FW-1:0]))
    else $error("lane 4 word not taken from low bits");
  masked_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wr_masked |=> $stable(lane_powerdown))
    else $error("masked write changed power-down vector");
  unmapped_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_rd_unmapped |=> wb_ack_o && wb_dat_o == rlc_pkg::RLC_UNMAPPED)
    else $error("unmapped read not zero");
  pd_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(lane_powerdown))
    else $error("power-down vector changed without write");
  pd_others_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $countones(lane_powerdown) == $countones({ctrl_r[0][rlc_pkg::RLC_PD_BIT],
      ctrl_r[1][rlc_pkg::RLC_PD_BIT], ctrl_r[2][rlc_pkg::RLC_PD_BIT]}))
    else $error("stray power-down element set");
  rst_vec_a: assert property (@(posedge ref_clk)
    !rst_n |=> lane_powerdown == '0)
    else $error("power-down vector not zero after reset");
  inv_rst_a: assert property (@(posedge ref_clk)
    !rst_n |=> !ctrl_r[0][rlc_pkg::RLC_INV_BIT] && !ctrl_r[1][rlc_pkg::RLC_INV_BIT]
      && !ctrl_r[2][rlc_pkg::RLC_INV_BIT])
    else $error("polarity bit not zero after reset");
  spare_rst46_a: assert property (@(posedge ref_clk)
    !rst_n |=> ctrl_r[0][rlc_pkg::RLC_SPARE_BIT] && ctrl_r[2][rlc_pkg::RLC_SPARE_BIT])
    else $error("lane 4 or 6 spare bit not one after reset");
endmodule // rlc_regs
`default_nettype wire

/* File: verification/rlc_far_model.sv */
// Far-side model: lane data sources, lane reset mask and fallback flag.
// Assumes lane data on ref_clk beside the register block.
`timescale 1ns/1ns
`default_nettype none
module rlc_far_model (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  lane_powerdown,
  output logic      [31:0] lane4_rx_data,
  output logic      [31:0] lane5_rx_data,
  output logic      [31:0] lane6_rx_data,
  output logic      [7:0]  rx_rst_mask,
  output logic             lane_fallback
);
  logic [31:0] cnt_r = 32'h0;
  always @(posedge ref_clk) cnt_r <= cnt_r + 32'h9E37_79B9;
  assign lane4_rx_data = cnt_r;
  assign lane5_rx_data = {cnt_r[15:0], cnt_r[31:16]};
  assign lane6_rx_data = cnt_r ^ 32'h5A5A_A5A5;
  assign rx_rst_mask   = lane_powerdown;
  assign lane_fallback = |lane_powerdown;
endmodule // rlc_far_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the lane 4..6 control registers.
// Assumes rlc_regs as a classic Wishbone slave and the far-side model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] OFFS [3] = '{rlc_pkg::RLC_LANE4_OFF, rlc_pkg::RLC_LANE5_OFF,
                                      rlc_pkg::RLC_LANE6_OFF};
  localparam int         IDX [3]  = '{4, 2, 6};
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack;
  logic [7:0]  pd;
  wire  [7:0]  rst_mask;
  wire         fallback;
  wire  [31:0] rx [3];
  wire  [31:0] dout [3];
  logic [31:0] prev [3];
  int          error_cnt = 0;
  int          compares = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) prev <= rx;
  rlc_regs u_rlc_regs (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .lane4_rx_data(rx[0]), .lane5_rx_data(rx[1]), .lane6_rx_data(rx[2]),
    .lane4_data_out(dout[0]), .lane5_data_out(dout[1]), .lane6_data_out(dout[2]),
    .lane_powerdown(pd));
  rlc_far_model u_rlc_far_model (.ref_clk(ref_clk), .lane_powerdown(pd),
    .lane4_rx_data(rx[0]), .lane5_rx_data(rx[1]), .lane6_rx_data(rx[2]),
    .rx_rst_mask(rst_mask), .lane_fallback(fallback));
  task automatic ck(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      ck(1'b0, "bus timeout");
      end_of_test();
    end
    rdat = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic ck_lane(input int i, input logic inv);
    @(negedge ref_clk);
    ck(dout[i] === (prev[i] ^ {32{inv}}), "lane data");
  endtask
  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, OFFS[i], 32'h0, 4'hF);
      ck(rdat === 32'h0000_0004, "reset value");
      ck_lane(i, 1'b0);
    end
    ck(pd === 8'h00, "vector at reset");
    $display("test reset done");
  endtask
  task automatic t_set;
    logic [7:0] exp_pd;
    exp_pd = 8'h00;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, OFFS[i], 32'hFFFF_FFFB, 4'hF);
      exp_pd[IDX[i]] = 1'b1;
      wb(1'b0, OFFS[i], 32'h0, 4'hF);
      ck(rdat === 32'h0000_0003, "readback");
      ck(pd === exp_pd, "vector");
      ck(rst_mask === exp_pd && fallback === 1'b1, "far side fallback");
      ck_lane(i, 1'b1);
    end
    $display("test set done");
  endtask
  task automatic t_refuse;
    wb(1'b1, OFFS[0], 32'h0, 4'hE);
    wb(1'b0, OFFS[0], 32'h0, 4'hF);
    ck(rdat === 32'h0000_0003, "masked write");
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    ck(rdat === 32'h0, "unmapped read");
    for (int i = 0; i < 3; i++) wb(1'b1, OFFS[i], 32'h0, 4'hF);
    wb(1'b0, OFFS[2], 32'h0, 4'hF);
    ck(rdat === 32'h0, "spare cleared");
    ck(pd === 8'h00, "vector cleared");
    ck(fallback === 1'b0, "fallback cleared");
    ck_lane(2, 1'b0);
    $display("test refuse done");
  endtask
  task automatic t_rerst;
    wb(1'b1, OFFS[1], 32'h0000_0006, 4'hF);
    wb(1'b0, OFFS[1], 32'h0, 4'hF);
    ck(rdat === 32'h0000_0006 && pd === 8'h04, "spare and lane 5 set");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(1'b0, OFFS[1], 32'h0, 4'hF);
    ck(rdat === 32'h0000_0004 && pd === 8'h00, "reset in run");
    $display("test rerst done");
  endtask
  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_set();
    t_refuse();
    t_rerst();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
